// >>> hdl/isr_evt_reg.sv
`timescale 1ns/1ps
module isr_evt_reg
  import isr_pkg::*;
#(
  parameter int           W    = 16,
  parameter logic [W-1:0] USED = '1
)(
  input  wire logic core_clk_i,
  input  wire logic rstn_i,
  isr_evt_if.regs   bus
);

  logic [W-1:0] cond_q;
  logic [W-1:0] rise;

  always_ff @(posedge core_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      cond_q <= '0;
    else
      cond_q <= bus.cond;
  end

  assign rise = bus.cond & ~cond_q;

  // [RULE20] clear on read, set wins
  always_ff @(posedge core_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      bus.evt <= '0;
    else
      bus.evt <= ((bus.rd_clr ? '0 : bus.evt) | rise | bus.set) & USED;
  end

  // [RULE21] and-or summary
  assign bus.summary = |(bus.evt & bus.enable & USED);

  property p_set_wins;
    @(posedge core_clk_i) disable iff (!rstn_i)
    (|(bus.set & USED)) |=> ((bus.evt & $past(bus.set & USED)) == $past(bus.set & USED));
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("event set lost"); // [RULE20]

  property p_rd_clr;
    @(posedge core_clk_i) disable iff (!rstn_i)
    (bus.rd_clr && !(|((rise | bus.set) & USED))) |=> (bus.evt == '0);
  endproperty
  a_rd_clr: assert property (p_rd_clr) else $error("event not cleared by read"); // [RULE20]

  property p_unused;
    @(posedge core_clk_i) disable iff (!rstn_i)
    ##1 ((bus.evt & ~USED) == '0);
  endproperty
  a_unused: assert property (p_unused) else $error("unused event bit set"); // [RULE22]

endmodule : isr_evt_reg

// >>> hdl/isr_top.sv
// Function
// [RULE1] ist is or of stb and ppe
// [RULE2] ist on parallel poll and query
// [RULE3] ppe mask written and read back
// [RULE4] device condition and event parts readable
// [RULE5] sensor error bits 3,4,9,10
// [RULE6] connector side bits 5,6,11,12
// [RULE7] bit 14 key held and pressed
// [RULE8] bit 15 always zero
// [RULE9] questionable condition and event readable
// [RULE10] questionable bits 3,4,8 mirror summaries
// [RULE11] questionable bit 9 self-test failure
// [RULE12] ese written, ese and esr readable
// [RULE13] opc sets bit 0 when idle
// [RULE14] query error sets bit 2
// [RULE15] device error bit 3, code queued
// [RULE16] execution error bit 4, code queued; code not queued when a device error comes in the same cycle
// [RULE17] command error bit 5, code queued; code not queued when a device or execution error comes in the same cycle
// [RULE18] local key sets bit 6
// [RULE19] power on sets bit 7
// [RULE20] event read returns then clears
// [RULE21] summary is or of event and enable
// [RULE22] unused bits read zero always
`timescale 1ns/1ps
`include "isr_map.svh"
module isr_top
  import isr_pkg::*;
(
  input  wire logic        core_clk_i,
  input  wire logic        rstn_i,
  input  wire logic        cmd_valid_i,
  input  wire logic [3:0]  cmd_code_i,
  input  wire logic [15:0] cmd_data_i,
  input  wire logic        talk_i,
  output logic             rsp_valid_o,
  output logic [15:0]      rsp_data_o,
  input  wire logic        ppoll_i,
  output logic             ppoll_resp_o,
  output logic             ist_o,
  input  wire logic [7:0]  stb_ext_i,
  input  wire logic [3:0]  sens_conn_i,
  input  wire logic [3:0]  sens_err_i,
  input  wire logic [3:0]  sens_rear_i,
  input  wire logic        key_held_i,
  input  wire logic        qpow_sum_i,
  input  wire logic        qwin_sum_i,
  input  wire logic        qcal_sum_i,
  input  wire logic        post_fail_i,
  input  wire logic        warn_i,
  input  wire logic        exec_idle_i,
  input  wire logic        dev_err_i,
  input  wire logic        exe_err_i,
  input  wire logic        cmd_err_i,
  input  wire logic        local_key_i,
  output logic             dev_sum_o,
  output logic             ques_sum_o,
  output logic             esb_o,
  output logic             err_push_o,
  output logic [15:0]      err_code_o
);

  isr_evt_if #(.W(16)) dev_if ();
  isr_evt_if #(.W(16)) ques_if ();
  isr_evt_if #(.W(8))  esr_if ();

  isr_rsp_e  rsp_state;
  isr_byte_t ppe;
  isr_byte_t ese;
  isr_word_t dev_enab;
  isr_word_t ques_enab;
  isr_byte_t stb;
  isr_byte_t esr_set;
  isr_word_t next_rsp;
  logic      ist_now;
  logic      rsp_load;
  logic      cmd_bad;
  logic      dev_rd;
  logic      ques_rd;
  logic      esr_rd;
  logic      opc_wait;
  logic      opc_fire;
  logic      qry_err;
  logic      cme_now;
  logic      pon_pend;

  // [RULE8] bit 15 tied low
  // [RULE4] device condition part
  // [RULE5] sensor error bits
  // [RULE6] front or rear bits
  // [RULE7] key held bit
  assign dev_if.cond = {1'b0, key_held_i, 1'b0,
                        sens_rear_i[3], sens_rear_i[2],
                        sens_err_i[3], sens_err_i[2],
                        sens_conn_i[3], sens_conn_i[2],
                        sens_rear_i[1], sens_rear_i[0],
                        sens_err_i[1], sens_err_i[0],
                        sens_conn_i[1], sens_conn_i[0], 1'b0};
  assign dev_if.set    = '0;
  assign dev_if.enable = dev_enab;
  assign dev_if.rd_clr = dev_rd;

  // [RULE10] sub-register summaries
  // [RULE11] self-test failure bit
  assign ques_if.cond = {1'b0, warn_i, 4'h0, post_fail_i, qcal_sum_i,
                         3'h0, qwin_sum_i, qpow_sum_i, 3'h0};
  assign ques_if.set    = '0;
  assign ques_if.enable = ques_enab;
  assign ques_if.rd_clr = ques_rd;

  assign esr_if.cond   = '0;
  assign esr_if.set    = esr_set;
  assign esr_if.enable = ese;
  assign esr_if.rd_clr = esr_rd;

  isr_evt_reg #(.W(16), .USED(`ISR_DEV_USED)) u_dev (
    .core_clk_i (core_clk_i),
    .rstn_i     (rstn_i),
    .bus        (dev_if)
  );

  isr_evt_reg #(.W(16), .USED(`ISR_QUES_USED)) u_ques (
    .core_clk_i (core_clk_i),
    .rstn_i     (rstn_i),
    .bus        (ques_if)
  );

  isr_evt_reg #(.W(8), .USED(`ISR_ESR_USED)) u_esr (
    .core_clk_i (core_clk_i),
    .rstn_i     (rstn_i),
    .bus        (esr_if)
  );

  assign dev_sum_o  = dev_if.summary;
  assign ques_sum_o = ques_if.summary;
  assign esb_o      = esr_if.summary;

  // status byte assembly
  always_comb
  begin
    stb                = stb_ext_i;
    stb[0]             = 1'b0;
    stb[`ISR_STB_DEV]  = dev_if.summary;
    stb[`ISR_STB_QUES] = ques_if.summary;
    stb[`ISR_STB_ESB]  = esr_if.summary;
  end

  // [RULE1] and with ppe, bit 6 kept
  assign ist_now = |(stb & ppe);

  // command decode
  always_comb
  begin
    rsp_load = 1'b0;
    next_rsp = '0;
    cmd_bad  = 1'b0;
    dev_rd   = 1'b0;
    ques_rd  = 1'b0;
    esr_rd   = 1'b0;
    if (cmd_valid_i)
      case (cmd_code_i)
        // [RULE2] ist query
        ISR_IST_Q:
        begin
          rsp_load = 1'b1;
          next_rsp = {15'h0000, ist_now};
        end
        // [RULE3] ppe readback
        ISR_PRE_Q:
        begin
          rsp_load = 1'b1;
          next_rsp = {8'h00, ppe};
        end
        // [RULE12] ese and esr readback
        ISR_ESE_Q:
        begin
          rsp_load = 1'b1;
          next_rsp = {8'h00, ese};
        end
        ISR_ESR_Q:
        begin
          rsp_load = 1'b1;
          esr_rd   = 1'b1;
          next_rsp = {8'h00, esr_if.evt};
        end
        // [RULE22] condition masked to used bits
        ISR_DEV_COND_Q:
        begin
          rsp_load = 1'b1;
          next_rsp = dev_if.cond & `ISR_DEV_USED;
        end
        ISR_DEV_EVT_Q:
        begin
          rsp_load = 1'b1;
          dev_rd   = 1'b1;
          next_rsp = dev_if.evt;
        end
        // [RULE9] questionable parts
        ISR_QUES_COND_Q:
        begin
          rsp_load = 1'b1;
          next_rsp = ques_if.cond & `ISR_QUES_USED;
        end
        ISR_QUES_EVT_Q:
        begin
          rsp_load = 1'b1;
          ques_rd  = 1'b1;
          next_rsp = ques_if.evt;
        end
        ISR_PRE, ISR_ESE, ISR_OPC, ISR_DEV_ENAB, ISR_QUES_ENAB:
          rsp_load = 1'b0;
        default:
          cmd_bad = 1'b1;
      endcase
  end

  // [RULE3] ppe write
  always_ff @(posedge core_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      ppe <= `ISR_PPE_RST;
    else if (cmd_valid_i && cmd_code_i == ISR_PRE)
      ppe <= cmd_data_i[7:0];
  end

  // [RULE12] ese write
  always_ff @(posedge core_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      ese <= `ISR_ESE_RST;
    else if (cmd_valid_i && cmd_code_i == ISR_ESE)
      ese <= cmd_data_i[7:0] & `ISR_ESR_USED;
  end

  // enable masks of device and questionable
  always_ff @(posedge core_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      dev_enab  <= `ISR_ENAB_RST;
      ques_enab <= `ISR_ENAB_RST;
    end
    else if (cmd_valid_i && cmd_code_i == ISR_DEV_ENAB)
      dev_enab <= cmd_data_i & `ISR_DEV_USED;
    else if (cmd_valid_i && cmd_code_i == ISR_QUES_ENAB)
      ques_enab <= cmd_data_i & `ISR_QUES_USED;
  end

  // response holding until collected
  always_ff @(posedge core_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      rsp_state <= RSP_IDLE;
    else if (cmd_valid_i)
      rsp_state <= rsp_load ? RSP_HOLD : RSP_IDLE;
    else if (talk_i)
      rsp_state <= RSP_IDLE;
  end

  always_ff @(posedge core_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      rsp_data_o <= '0;
    else if (rsp_load)
      rsp_data_o <= next_rsp;
  end

  assign rsp_valid_o = (rsp_state == RSP_HOLD);

  // [RULE2] parallel poll answer
  always_ff @(posedge core_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      ist_o        <= 1'b0;
      ppoll_resp_o <= 1'b0;
    end
    else
    begin
      ist_o        <= ist_now;
      ppoll_resp_o <= ppoll_i;
    end
  end

  // [RULE13] opc waits for idle
  always_ff @(posedge core_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      opc_wait <= 1'b0;
    else if (cmd_valid_i && cmd_code_i == ISR_OPC)
      opc_wait <= 1'b1;
    else if (exec_idle_i)
      opc_wait <= 1'b0;
  end

  assign opc_fire = opc_wait && exec_idle_i;

  // [RULE19] power on pending
  always_ff @(posedge core_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      pon_pend <= 1'b1;
    else
      pon_pend <= 1'b0;
  end

  // [RULE14] read idle or command while held
  assign qry_err = (talk_i && rsp_state == RSP_IDLE) || (cmd_valid_i && rsp_state == RSP_HOLD);
  assign cme_now = cmd_err_i || cmd_bad;

  // [RULE15] [RULE16] [RULE17] [RULE18] event bits
  always_comb
  begin
    esr_set               = '0;
    esr_set[`ISR_ESR_OPC] = opc_fire;
    esr_set[`ISR_ESR_QRY] = qry_err;
    esr_set[`ISR_ESR_DDE] = dev_err_i;
    esr_set[`ISR_ESR_EXE] = exe_err_i;
    esr_set[`ISR_ESR_CME] = cme_now;
    esr_set[`ISR_ESR_URQ] = local_key_i;
    esr_set[`ISR_ESR_PON] = pon_pend;
  end

  // [RULE15] [RULE16] [RULE17] one error code queued per cycle, device over execution over command
  always_ff @(posedge core_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      err_push_o <= 1'b0;
      err_code_o <= '0;
    end
    else
    begin
      err_push_o <= dev_err_i || exe_err_i || cme_now;
      if (dev_err_i)
        err_code_o <= `ISR_ERR_DEV;
      else if (exe_err_i)
        err_code_o <= `ISR_ERR_EXE;
      else if (cme_now)
        err_code_o <= `ISR_ERR_CMD;
    end
  end

  property p_ppoll;
    @(posedge core_clk_i) disable iff (!rstn_i)
    ppoll_i |=> (ppoll_resp_o && ist_o == $past(ist_now));
  endproperty
  a_ppoll: assert property (p_ppoll) else $error("parallel poll answer wrong"); // [RULE2]

  property p_ist_q;
    @(posedge core_clk_i) disable iff (!rstn_i)
    (cmd_valid_i && cmd_code_i == ISR_IST_Q) |=> (rsp_valid_o && rsp_data_o == {15'h0000, $past(|(stb & ppe))});
  endproperty
  a_ist_q: assert property (p_ist_q) else $error("ist query answer wrong"); // [RULE1]

  property p_pre;
    @(posedge core_clk_i) disable iff (!rstn_i)
    (cmd_valid_i && cmd_code_i == ISR_PRE) ##1 !cmd_valid_i ##1 (cmd_valid_i && cmd_code_i == ISR_PRE_Q)
      |=> (rsp_data_o[7:0] == $past(cmd_data_i[7:0], 3));
  endproperty
  a_pre: assert property (p_pre) else $error("ppe readback wrong"); // [RULE3]

  property p_bit15;
    @(posedge core_clk_i) disable iff (!rstn_i)
    ##1 (!rsp_data_o[15] && !dev_if.evt[15] && !ques_if.evt[15]);
  endproperty
  a_bit15: assert property (p_bit15) else $error("bit 15 set"); // [RULE8]

  property p_opc;
    @(posedge core_clk_i) disable iff (!rstn_i)
    (cmd_valid_i && cmd_code_i == ISR_OPC && !esr_rd) ##1 (exec_idle_i && !esr_rd)
      |=> esr_if.evt[`ISR_ESR_OPC];
  endproperty
  a_opc: assert property (p_opc) else $error("opc bit not set"); // [RULE13]

  property p_qerr;
    @(posedge core_clk_i) disable iff (!rstn_i)
    (talk_i && !rsp_valid_o) |=> esr_if.evt[`ISR_ESR_QRY];
  endproperty
  a_qerr: assert property (p_qerr) else $error("query error not flagged"); // [RULE14]

  property p_cme;
    @(posedge core_clk_i) disable iff (!rstn_i)
    (cmd_bad && !dev_err_i && !exe_err_i) |=> (err_push_o && err_code_o == `ISR_ERR_CMD && esr_if.evt[`ISR_ESR_CME]);
  endproperty
  a_cme: assert property (p_cme) else $error("command error not queued"); // [RULE17]

  property p_pon;
    @(posedge core_clk_i) disable iff (!rstn_i)
    pon_pend |=> (esr_if.evt[`ISR_ESR_PON] && !pon_pend);
  endproperty
  a_pon: assert property (p_pon) else $error("power on bit missing"); // [RULE19]

endmodule : isr_top

// >>> pkg/isr_evt_if.sv
`timescale 1ns/1ps
interface isr_evt_if #(parameter int W = 16);
  logic [W-1:0] cond;
  logic [W-1:0] set;
  logic [W-1:0] enable;
  logic [W-1:0] evt;
  logic         rd_clr;
  logic         summary;

  modport owner (output cond, set, enable, rd_clr, input evt, summary);
  modport regs  (input cond, set, enable, rd_clr, output evt, summary);
endinterface : isr_evt_if

// >>> pkg/isr_map.svh
`ifndef ISR_MAP_SVH
`define ISR_MAP_SVH

// used-bit masks, bit 15 never set
`define ISR_DEV_USED   16'h5FFE
`define ISR_QUES_USED  16'h4318
`define ISR_ESR_USED   8'hFD

// reset values of writable masks
`define ISR_PPE_RST    8'h00
`define ISR_ESE_RST    8'h00
`define ISR_ENAB_RST   16'h0000

// standard event bit positions
`define ISR_ESR_OPC    0
`define ISR_ESR_QRY    2
`define ISR_ESR_DDE    3
`define ISR_ESR_EXE    4
`define ISR_ESR_CME    5
`define ISR_ESR_URQ    6
`define ISR_ESR_PON    7

// status byte positions built here
`define ISR_STB_DEV    1
`define ISR_STB_QUES   3
`define ISR_STB_ESB    5

// error queue codes
`define ISR_ERR_DEV    16'hFED4
`define ISR_ERR_EXE    16'hFF38
`define ISR_ERR_CMD    16'hFF9C

`endif

// >>> pkg/isr_pkg.sv
package isr_pkg;

  typedef enum logic [3:0] {
    ISR_IST_Q      = 4'h0,
    ISR_PRE        = 4'h1,
    ISR_PRE_Q      = 4'h2,
    ISR_ESE        = 4'h3,
    ISR_ESE_Q      = 4'h4,
    ISR_ESR_Q      = 4'h5,
    ISR_OPC        = 4'h6,
    ISR_DEV_COND_Q = 4'h7,
    ISR_DEV_EVT_Q  = 4'h8,
    ISR_DEV_ENAB   = 4'h9,
    ISR_QUES_COND_Q = 4'hA,
    ISR_QUES_EVT_Q = 4'hB,
    ISR_QUES_ENAB  = 4'hC
  } isr_cmd_e;

  typedef enum logic [1:0] {
    RSP_IDLE = 2'b00,
    RSP_HOLD = 2'b01
  } isr_rsp_e;

  typedef logic [15:0] isr_word_t;
  typedef logic [7:0]  isr_byte_t;

endpackage : isr_pkg

// >>> tb/isr_ctrl_model.sv
`timescale 1ns/1ps
module isr_ctrl_model
  import isr_pkg::*;
(
  input  wire logic        core_clk_i,
  input  wire logic        rsp_valid_i,
  input  wire logic [15:0] rsp_data_i,
  input  wire logic        ppoll_resp_i,
  input  wire logic        ist_i,
  output logic             cmd_valid_o,
  output logic [3:0]       cmd_code_o,
  output logic [15:0]      cmd_data_o,
  output logic             talk_o,
  output logic             ppoll_o
);
  initial
  begin
    cmd_valid_o = 1'b0;
    cmd_code_o  = 4'h0;
    cmd_data_o  = 16'h0000;
    talk_o      = 1'b0;
    ppoll_o     = 1'b0;
  end

  task automatic send(input logic [3:0] code, input logic [15:0] data);
    @(posedge core_clk_i);
    cmd_valid_o <= 1'b1;
    cmd_code_o  <= code;
    cmd_data_o  <= data;
    @(posedge core_clk_i);
    cmd_valid_o <= 1'b0;
    cmd_data_o  <= ~data;
  endtask : send

  task automatic talk;
    @(posedge core_clk_i);
    talk_o <= 1'b1;
    @(posedge core_clk_i);
    talk_o <= 1'b0;
  endtask : talk

  task automatic query(input logic [3:0] code, output logic [15:0] data);
    int i;
    send(code, 16'h0000);
    @(negedge core_clk_i);
    for (i = 0; i < 4 && rsp_valid_i !== 1'b1; i++)
      @(negedge core_clk_i);
    data = (rsp_valid_i === 1'b1) ? rsp_data_i : 'x;
    talk();
  endtask : query

  task automatic poll(output logic ist);
    @(posedge core_clk_i);
    ppoll_o <= 1'b1;
    @(posedge core_clk_i);
    ppoll_o <= 1'b0;
    @(negedge core_clk_i);
    ist = (ppoll_resp_i === 1'b1) ? ist_i : 1'bx;
  endtask : poll
endmodule : isr_ctrl_model

// >>> tb/tb_instrument_status_reporting.sv
`timescale 1ns/1ps
module tb_instrument_status_reporting
  import isr_pkg::*;
;
  logic        core_clk_i, rstn_i, cmd_valid, talk, ppoll, rsp_valid, ppoll_resp, ist, b;
  logic [3:0]  cmd_code, conn, err, rear;
  logic [15:0] cmd_data, rsp_data, err_code;
  logic [7:0]  stb_ext;
  logic        key, qpow, qwin, qcal, post, warn, idle, dev_err, exe_err, cmd_err, lkey;
  logic        dev_sum, ques_sum, esb, err_push;
  logic [15:0] codes [4] = '{16'hFED4, 16'hFF38, 16'hFF9C, 16'h0000};
  int          errors = 0;
  int          samples_checked = 0;
  int          cycles = 0;

  isr_top u_dut (.core_clk_i(core_clk_i), .rstn_i(rstn_i), .cmd_valid_i(cmd_valid),
    .cmd_code_i(cmd_code), .cmd_data_i(cmd_data), .talk_i(talk), .rsp_valid_o(rsp_valid),
    .rsp_data_o(rsp_data), .ppoll_i(ppoll), .ppoll_resp_o(ppoll_resp), .ist_o(ist),
    .stb_ext_i(stb_ext), .sens_conn_i(conn), .sens_err_i(err), .sens_rear_i(rear),
    .key_held_i(key), .qpow_sum_i(qpow), .qwin_sum_i(qwin), .qcal_sum_i(qcal),
    .post_fail_i(post), .warn_i(warn), .exec_idle_i(idle), .dev_err_i(dev_err),
    .exe_err_i(exe_err), .cmd_err_i(cmd_err), .local_key_i(lkey), .dev_sum_o(dev_sum),
    .ques_sum_o(ques_sum), .esb_o(esb), .err_push_o(err_push), .err_code_o(err_code));

  isr_ctrl_model u_ctrl (.core_clk_i(core_clk_i), .rsp_valid_i(rsp_valid),
    .rsp_data_i(rsp_data), .ppoll_resp_i(ppoll_resp), .ist_i(ist), .cmd_valid_o(cmd_valid),
    .cmd_code_o(cmd_code), .cmd_data_o(cmd_data), .talk_o(talk), .ppoll_o(ppoll));

  initial
  begin
    core_clk_i = 1'b0;
    forever #20 core_clk_i = ~core_clk_i;
  end

  task automatic print_verdict;
    if (errors == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : print_verdict

  always @(posedge core_clk_i)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      errors++;
      print_verdict();
    end
  end

  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e)
    begin
      errors++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic q(input string n, input logic [3:0] c, input logic [15:0] e);
    logic [15:0] d;
    u_ctrl.query(c, d);
    chk(n, e, d);
  endtask : q

  // error or local key pulse, code queued for errors only, esr bit
  task automatic fire(input int k);
    int i;
    @(posedge core_clk_i);
    {lkey, cmd_err, exe_err, dev_err} <= 4'h1 << k;
    @(posedge core_clk_i);
    {lkey, cmd_err, exe_err, dev_err} <= 4'h0;
    @(negedge core_clk_i);
    for (i = 0; i < 3 && err_push !== 1'b1; i++)
      @(negedge core_clk_i);
    chk("err_push", {15'h0, k < 3}, {15'h0, err_push});
    if (k < 3)
      chk("err_code", codes[k], err_code);
    q("esr_evt", ISR_ESR_Q, 16'h0008 << k);
  endtask : fire

  initial
  begin
    rstn_i = 1'b0;
    stb_ext = 8'h00;
    {conn, err, rear, key} = 13'h0;
    {qpow, qwin, qcal, post, warn, idle} = 6'h0;
    {lkey, cmd_err, exe_err, dev_err} = 4'h0;
    repeat (8) @(posedge core_clk_i);
    rstn_i <= 1'b1;
    q("esr_pon", ISR_ESR_Q, 16'h0080);
    q("esr_clr", ISR_ESR_Q, 16'h0000);
    stb_ext <= 8'h40;
    u_ctrl.send(ISR_PRE, 16'h0040);
    q("pre", ISR_PRE_Q, 16'h0040);
    q("ist_q", ISR_IST_Q, 16'h0001);
    u_ctrl.poll(b);
    chk("ist_poll", 16'h0001, {15'h0, b});
    u_ctrl.send(ISR_PRE, 16'h00BF);
    q("ist_off", ISR_IST_Q, 16'h0000);
    {conn, err, rear, key} <= 13'h1FFF;
    repeat (2) @(posedge core_clk_i);
    {err, rear, key} <= 9'h0AA;
    q("dev_cond", ISR_DEV_COND_Q, 16'h0BAE);
    q("dev_evt", ISR_DEV_EVT_Q, 16'h5FFE);
    q("dev_evt_clr", ISR_DEV_EVT_Q, 16'h0000);
    u_ctrl.send(ISR_DEV_ENAB, 16'hFFFF);
    key <= 1'b1;
    repeat (3) @(negedge core_clk_i);
    chk("dev_sum", 16'h0001, {15'h0, dev_sum});
    u_ctrl.send(ISR_PRE, 16'h0002);
    q("ist_dev", ISR_IST_Q, 16'h0001);
    q("dev_evt_key", ISR_DEV_EVT_Q, 16'h4000);
    @(negedge core_clk_i);
    chk("dev_sum_clr", 16'h0000, {15'h0, dev_sum});
    @(posedge core_clk_i);
    {qpow, qwin, qcal, post, warn} <= 5'h1F;
    q("ques_cond", ISR_QUES_COND_Q, 16'h4318);
    {qpow, qwin, qcal, post, warn} <= 5'h00;
    u_ctrl.send(ISR_QUES_ENAB, 16'h0200);
    @(negedge core_clk_i);
    chk("ques_sum", 16'h0001, {15'h0, ques_sum});
    q("ques_cond0", ISR_QUES_COND_Q, 16'h0000);
    q("ques_evt", ISR_QUES_EVT_Q, 16'h4318);
    u_ctrl.send(ISR_ESE, 16'h0020);
    q("ese", ISR_ESE_Q, 16'h0020);
    for (int i = 0; i < 4; i++)
      fire(i);
    u_ctrl.send(4'hD, 16'h0000);
    repeat (2) @(negedge core_clk_i);
    chk("esb", 16'h0001, {15'h0, esb});
    q("esr_cme", ISR_ESR_Q, 16'h0020);
    @(negedge core_clk_i);
    chk("esb_clr", 16'h0000, {15'h0, esb});
    u_ctrl.talk();
    q("qerr_talk", ISR_ESR_Q, 16'h0004);
    u_ctrl.send(ISR_ESE_Q, 16'h0000);
    u_ctrl.send(ISR_PRE, 16'h0002);
    q("qerr_cmd", ISR_ESR_Q, 16'h0004);
    u_ctrl.send(ISR_OPC, 16'h0000);
    repeat (4) @(posedge core_clk_i);
    q("opc_busy", ISR_ESR_Q, 16'h0000);
    u_ctrl.send(ISR_OPC, 16'h0000);
    idle <= 1'b1;
    repeat (3) @(posedge core_clk_i);
    q("opc_done", ISR_ESR_Q, 16'h0001);
    print_verdict();
  end
endmodule : tb_instrument_status_reporting
